// ---- design/cal_clock_value.sv ----
// Purpose: Calendar time-of-day register with second-by-second counting.
// Assumes: Strobes are one cycle and never both high together.
// Notes: Read data appears in the cycle after the read strobe only.
`timescale 1ns/1ps
// How it works
// RL1 - Count only in clock/calendar mode two
// RL2 - Year offset lives in bits 31:26
// RL3 - Leap year when year bits 1:0 zero
// RL4 - Month bits 25:22, one through twelve
// RL5 - Day bits 21:17, month-length bounded
// RL6 - 24-hour hour field, zero to 23
// RL7 - 12-hour form: 1-12 plus PM bit
// RL8 - Minute bits 11:6, zero to 59
// RL9 - Seconds roll over carrying upward fully
module cal_clock_value
    import cal_clock_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_second_tick
);
    // ****************************************
    // Helpers
    // ****************************************
    // Last day of a month; February depends on the year offset.
    function automatic logic [4:0] month_days(input logic [3:0] m, input logic [5:0] y);
        logic [4:0] d;
        d = 5'h1F;
        case (m)
            4'h4, 4'h6, 4'h9, 4'hB: d = 5'h1E;
            MONTH_FEB: d = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C; // see RL3
            default: d = 5'h1F;
        endcase
        return d;
    endfunction

    // Address match for one register offset; the write and read paths share it.
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    // Writable control bits: enable, the two mode bits and the hour format select.
    // Built from the field positions so a moved field cannot leave a stale mask.
    function automatic logic [31:0] ctrl_mask();
        logic [31:0] m;
        m = 32'h00000000;
        m[CTRL_ENABLE_BIT] = 1'b1;
        m[CTRL_MODE_LSB +: 2] = 2'h3;
        m[CTRL_HOUR_FMT_BIT] = 1'b1;
        return m;
    endfunction

    // Hour that follows a full hour, in either format.
    function automatic logic [4:0] next_hour(input logic [4:0] h, input logic f12);
        logic [4:0] n;
        n = h;
        if (f12) begin
            // 11 -> 12 flips AM/PM; 12 -> 1 keeps it.
            if (h[3:0] >= HOUR12_MAX) begin // see RL7
                n[3:0] = 4'h1;
            end else begin
                n[3:0] = h[3:0] + 4'h1;
                if (h[3:0] == HOUR12_MAX - 4'h1) begin
                    n[4] = ~h[4];
                end
            end
        end else if (h >= HOUR24_MAX) begin // see RL6
            n = 5'h00;
        end else begin
            n = h + 5'h01;
        end
        return n;
    endfunction

    // Last hour of the day: 11 PM in 12-hour form, 23 in 24-hour form.
    // In 12-hour form the AM 11 -> 12 step is noon and must not move the day.
    function automatic logic last_hour(input logic [4:0] h, input logic f12);
        logic l;
        if (f12) begin
            l = h[4] && (h[3:0] == HOUR12_MAX - 4'h1); // see RL7
        end else begin
            l = (h >= HOUR24_MAX); // see RL6
        end
        return l;
    endfunction

    cal_time_t time_r, time_nxt;
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [26:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic run;
    logic fmt12;
    logic time_wr;
    logic ctrl_wr;
    logic [26:0] div_last;

    assign fmt12 = ctrl_r[CTRL_HOUR_FMT_BIT];
    // Counting needs both enable and calendar mode; other modes leave the word untouched.
    assign run = ctrl_r[CTRL_ENABLE_BIT]
        && (ctrl_r[CTRL_MODE_LSB +: 2] == MODE_CLOCK_CALENDAR); // see RL1
    // Writes are decoded once so every group below acts on the same decision.
    assign time_wr = i_wr && addr_hit(i_addr, OFS_CALENDAR_TIME_VALUE);
    assign ctrl_wr = i_wr && addr_hit(i_addr, OFS_CONTROL_REGISTER_A);
    // Terminal count of the divider, cut to the divider's width on purpose.
    assign div_last = 27'(TICK_COUNT - 1);

    // ****************************************
    // Control register
    // ****************************************
    // Bits outside the mask read back as zero, so software cannot park state there.
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr) begin
            ctrl_nxt = i_wdata & ctrl_mask();
        end
    end

    // Control register flip-flops; the clock enable freezes them.
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            ctrl_r <= CONTROL_A_RESET;
        end else if (i_clk_en) begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ****************************************
    // Second divider
    // ****************************************
    // The divider counts core cycles up to one second while counting is allowed.
    // A time write restarts it and swallows a tick due in the same cycle, so the
    // tick output only pulses when the seconds field really advances.
    always_comb begin
        div_nxt = div_r;
        tick_nxt = 1'b0;
        if (!run) begin
            div_nxt = 27'h0000000; // see RL1
        end else if (div_r >= div_last) begin
            div_nxt = 27'h0000000;
            tick_nxt = 1'b1;
        end else begin
            div_nxt = div_r + 27'h0000001;
        end
        if (time_wr) begin
            div_nxt = 27'h0000000;
            tick_nxt = 1'b0;
        end
    end

    // Divider flip-flops; a frozen clock enable also holds a pending tick.
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            div_r <= 27'h0000000;
            tick_r <= 1'b0;
        end else if (i_clk_en) begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // ****************************************
    // Calendar time word
    // ****************************************
    // A software write takes priority over the tick, so a value written lands exactly.
    // Written fields are not range checked; an over-range value rolls over at its next step as if it were the maximum.
    always_comb begin
        time_nxt = time_r;
        if (tick_nxt) begin
            if (time_r.second >= SEC_MAX) begin // see RL9
                time_nxt.second = 6'h00;
                if (time_r.minute >= MIN_MAX) begin // see RL8
                    time_nxt.minute = 6'h00;
                    time_nxt.hour = next_hour(time_r.hour, fmt12);
                    // Day advances on the midnight crossing only.
                    if (last_hour(time_r.hour, fmt12)) begin
                        if (time_r.day >= month_days(time_r.month, time_r.year)) begin // see RL5
                            time_nxt.day = DAY_FIRST;
                            if (time_r.month >= MONTH_MAX) begin // see RL4
                                time_nxt.month = 4'h1;
                                time_nxt.year = time_r.year + 6'h01; // see RL2
                            end else begin
                                time_nxt.month = time_r.month + 4'h1;
                            end
                        end else begin
                            time_nxt.day = time_r.day + 5'h01;
                        end
                    end
                end else begin
                    time_nxt.minute = time_r.minute + 6'h01;
                end
            end else begin
                time_nxt.second = time_r.second + 6'h01;
            end
        end
        if (time_wr) begin
            time_nxt = cal_time_t'(i_wdata); // see RL2
        end
    end

    // Time word flip-flops; the clock enable freezes them.
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            time_r <= cal_time_t'(CALENDAR_TIME_RESET);
        end else if (i_clk_en) begin
            time_r <= time_nxt;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    // Read data stand for one cycle only and are zero otherwise, so a stale value
    // can never be mistaken for a fresh answer.
    always_comb begin
        rdata_nxt = 32'h00000000;
        if (i_rd) begin
            if (addr_hit(i_addr, OFS_CALENDAR_TIME_VALUE)) begin
                rdata_nxt = time_r;
            end else if (addr_hit(i_addr, OFS_CONTROL_REGISTER_A)) begin
                rdata_nxt = ctrl_r;
            end
        end
    end

    // Read data flip-flops; the clock enable freezes them as well.
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            rdata_r <= 32'h00000000;
        end else if (i_clk_en) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Both outputs come straight from flip-flops.
    assign o_rdata = rdata_r;
    assign o_second_tick = tick_r;
endmodule

// ---- inc/cal_clock_pkg.sv ----
// Purpose: Constants and types for the calendar time value block.
// Assumes: 32-bit register port, word-aligned byte offsets.
// Notes: Field positions match the packed calendar time word.
package cal_clock_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_CALENDAR_TIME_VALUE = 8'h18;
    localparam logic [7:0] OFS_CONTROL_REGISTER_A = 8'h00;
    localparam logic [31:0] CALENDAR_TIME_RESET = 32'h00000000;
    localparam logic [31:0] CONTROL_A_RESET = 32'h00000000;
    // Control register A field positions.
    localparam int CTRL_ENABLE_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam int CTRL_HOUR_FMT_BIT = 6;
    localparam logic [1:0] MODE_CLOCK_CALENDAR = 2'h2;
    // ****************************************
    // Field limits
    // ****************************************
    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [4:0] HOUR24_MAX = 5'h17;
    localparam logic [3:0] HOUR12_MAX = 4'hC;
    localparam logic [3:0] MONTH_MAX = 4'hC;
    localparam logic [3:0] MONTH_FEB = 4'h2;
    localparam logic [4:0] DAY_FIRST = 5'h01;
    // Seconds tick: one second at 100 MHz core clock.
    localparam int CLK_HZ = 100000000;
    localparam int TICK_CYCLES = CLK_HZ;
    // Packed calendar word, most significant field first.
    typedef struct packed {
        logic [5:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } cal_time_t;
endpackage

// ---- test/cal_clock_checker.sv ----
// Purpose: Port assertions for the calendar time block.
// Assumes: Written time fields stay in range.
// Notes: Bound to the block below.
`timescale 1ns/1ps
module cal_clock_checker #(parameter int TICK_COUNT = 4) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_second_tick
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    a_rdata_idle: assert property (i_clk_en && !i_rd |=> o_rdata == 32'h0) else $error("idle");
    a_unmapped_zero: assert property (i_rd && i_clk_en && !(i_addr inside {8'h00, 8'h18}) |=> o_rdata == 32'h0) else $error("hole");
    a_ctrl_mask: assert property (i_rd && i_clk_en && i_addr == 8'h00 |=> (o_rdata & 32'hFFFFFFB1) == 32'h0) else $error("mask");
    a_sec_range: assert property (i_rd && i_clk_en && i_addr == 8'h18 |=> o_rdata[5:0] <= 6'h3B && o_rdata[11:6] <= 6'h3B) else $error("sec");
    a_month_range: assert property (i_rd && i_clk_en && i_addr == 8'h18 |=> o_rdata[25:22] <= 4'hC) else $error("month");
    a_write_read: assert property (i_wr && i_clk_en && i_addr == 8'h18 ##1 i_rd && i_clk_en && i_addr == 8'h18
        |=> o_rdata == $past(i_wdata, 2)) else $error("readback");
    a_rdata_freeze: assert property (!i_clk_en |=> $stable(o_rdata)) else $error("freeze");
    a_tick_gap: assert property (o_second_tick && i_clk_en |=> !o_second_tick[*3]) else $error("tick");
endmodule
bind cal_clock_value cal_clock_checker #(.TICK_COUNT(TICK_COUNT)) chk_u (.i_core_clk(i_core_clk),
    .i_resetn(i_resetn), .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_second_tick(o_second_tick));

// ---- test/cal_clock_value_tb_top.sv ----
// Purpose: Bench for the calendar time block.
// Assumes: A four-cycle second.
// Notes: The monitor compares queued reads.
`timescale 1ns/1ps
module cal_clock_value_tb_top;
    logic clk = 0, rstn = 0, en = 1, wr = 0, rd = 0, rd_q = 0, tick;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, v, r = 32'h62D305CA, exp_q[$];
    int err_count = 0, cmp_count = 0, cyc = 0, ticks = 0;
    cal_clock_value #(.TICK_COUNT(4)) dut_u (.i_core_clk(clk), .i_resetn(rstn), .i_clk_en(en), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_second_tick(tick));
    always #5 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) $display("MISMATCH %s expected %h seen %h", name, want, seen);
        err_count += int'(seen !== want);
    endtask
    task automatic stop_test();
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Read data stand only in the cycle after the strobe, so they are compared there.
    always @(posedge clk) begin
        if (rd_q) chk("rdata", rdata, exp_q.pop_front());
        if (tick === 1'b1) ticks++;
        rd_q <= rd && en;
        if (++cyc > 3000) err_count++;
        if (cyc > 3000) stop_test();
    end
    task automatic bus(input int k, input logic [7:0] a, input logic [31:0] d);
        wr <= k == 1;
        rd <= k == 2;
        addr <= a;
        wdata <= d;
        if (k == 2) exp_q.push_back(d);
        @(posedge clk);
    endtask
    task automatic roll(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b, input int nt);
        int t0;
        t0 = ticks;
        bus(1, 8'h00, c);
        bus(1, 8'h18, a);
        en <= 0;
        repeat (6) bus(0, 8'h00, 32'h0);
        en <= 1;
        repeat (5) bus(0, 8'h00, 32'h0);
        bus(2, 8'h18, b);
        chk("second ticks", 32'(ticks - t0), 32'(nt));
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1;
        bus(2, 8'h18, 32'h0);
        bus(2, 8'h04, 32'h0);
        bus(1, 8'h00, 32'hFFFFFFFF);
        bus(2, 8'h00, 32'h4E);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            v = {r[31:26], 4'(r[25:22]%12+1), 5'(r[21:17]%28+1), 5'(r[16:12]%24), 6'(r[11:6]%60), 6'(r[5:0]%60)};
            bus(1, 8'h18, v);
            bus(2, 8'h18, v);
        end
        roll(32'h4E, 32'h10B97EFB, 32'h10B97EFB, 0);
        roll(32'hA, 32'h10B97EFB, 32'h10BA0000, 1);
        roll(32'hA, 32'h0CB97EFB, 32'h0CC20000, 1);
        roll(32'hA, 32'hFF3F7EFB, 32'h00420000, 1);
        roll(32'h4A, 32'h144ABEFB, 32'h144BC000, 1);
        roll(32'h4A, 32'h144BBEFB, 32'h144CC000, 1);
        #15 stop_test();
    end
endmodule
